/* logic/pwm_pkg.sv */
// constants, carriers and field layout of the two-channel pwm unit
// Function
// R1 - duty value is duty low register above the two duty fraction bits
// R2 - after counter equals period: clear counter, set pin unless duty zero, load shadow
// R3 - in pwm mode software writes to the duty shadow register are ignored
// R4 - postscaler only paces the period match flag, never the pwm period
// R5 - shadow byte and hidden 2-bit latch reload only at the period boundary
// R6 - 10-bit time base is counter with two low-order bits appended
// R7 - prescale 1:1 takes low bits from clock phase, else from prescaler
// R8 - pin clears when time base equals shadow byte with latch
// R9 - full ten-bit resolution at period 255, fewer bits for smaller periods
// R10 - duty above period never matches, pin keeps its level
// R11 - prescaler divides by 1, 4 or 16
// R12 - sleep stops counter, freezes state, pin keeps its level
// R13 - after sleep the counter continues from its held value
// R14 - pwm timing is derived straight from the system clock
// R15 - reset restores register defaults and turns pins to input
// R16 - software sets up direction, period, mode, duty, flag, prescale, then run
// R17 - software waits for period match flag before enabling the pin driver
// R18 - unit control: bits 5:4 duty fraction, 3:0 mode, 7:6 read zero
// R19 - timer control: 6:3 postscale, bit 2 run, 1:0 prescale
// R20 - pwm level goes to pin mux, driven only when direction selects output
package pwm_pkg;

	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFF_CTL1   = 8'h00;
	localparam logic [7:0] OFF_CTL2   = 8'h04;
	localparam logic [7:0] OFF_DUTY1  = 8'h08;
	localparam logic [7:0] OFF_DUTY2  = 8'h0c;
	localparam logic [7:0] OFF_SHAD1  = 8'h10;
	localparam logic [7:0] OFF_SHAD2  = 8'h14;
	localparam logic [7:0] OFF_PERIOD = 8'h18;
	localparam logic [7:0] OFF_TCTL   = 8'h1c;
	localparam logic [7:0] OFF_COUNT  = 8'h20;
	localparam logic [7:0] OFF_STATUS = 8'h24;
	localparam logic [7:0] OFF_DIR    = 8'h28;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CTL_FRAC_LSB  = 4;
	localparam int CTL_MODE_LSB  = 0;
	localparam int TCTL_POST_LSB = 3;
	localparam int TCTL_RUN_BIT  = 2;
	localparam int TCTL_PRE_LSB  = 0;
	localparam int STAT_FLAG_BIT = 0;

	// ----------------------------------------
	// reset values and codes
	// ----------------------------------------
	localparam logic [5:0] RST_CTL    = 6'h00;
	localparam logic [7:0] RST_DUTY   = 8'h00;
	localparam logic [7:0] RST_PERIOD = 8'hff;
	localparam logic [6:0] RST_TCTL   = 7'h00;
	localparam logic [7:0] RST_COUNT  = 8'h00;
	localparam logic [1:0] RST_DIR    = 2'h3;  // both pins input
	localparam logic [1:0] MODE_PWM   = 2'h3;  // mode bits 3:2 both set
	localparam logic [1:0] PRE_DIV1   = 2'h0;
	localparam logic [1:0] PRE_DIV4   = 2'h1;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic       run;
		logic [1:0] pre;
		logic [3:0] post;
	} timer_cfg_t;

	typedef struct packed {
		logic [9:0] base;
		logic       boundary;
	} timebase_t;

endpackage

/* logic/pwm_timebase.sv */
// period timer, prescaler, clock phase and postscaler of the pwm unit
`timescale 1ns/10ps
module pwm_timebase import pwm_pkg::*; (
	input  logic       aclk,        // system clock
	input  logic       aresetn,     // synchronous reset, low
	input  logic       sleep,       // freeze all counting
	input  timer_cfg_t cfg,         // run, prescale, postscale
	input  logic [7:0] period,      // period register
	input  logic       count_wr,    // software load of counter
	input  logic [7:0] count_wdata, // value to load
	output timebase_t  tb,          // 10-bit base and boundary pulse
	output logic [7:0] count,       // counter value
	output logic       post_match   // postscaled period match pulse
);
	logic [1:0] phase_reg, phase_next;
	logic [3:0] pre_reg, pre_next;
	logic [7:0] count_reg, count_next;
	logic [3:0] post_reg, post_next;
	logic       tcy, pre_term, tick, boundary;
	logic [1:0] low_bits;

	// phase counts system clocks, an instruction cycle is four of them
	assign phase_next = sleep ? phase_reg : phase_reg + 2'h1;  // see R14 see R12
	assign tcy        = (phase_reg == 2'h3) & ~sleep;
	assign pre_next   = (tcy & cfg.run) ? pre_reg + 4'h1 : pre_reg;
	assign pre_term   = (cfg.pre == PRE_DIV1) ? 1'b1 :
	                    (cfg.pre == PRE_DIV4) ? (pre_reg[1:0] == 2'h3) :
	                    (pre_reg == 4'hf);                       // see R11
	assign tick       = tcy & cfg.run & pre_term;
	assign boundary   = tick & (count_reg == period);
	// counter restarts after the period match, holds through sleep
	assign count_next = count_wr ? count_wdata :
	                    boundary ? 8'h00 :
	                    tick     ? count_reg + 8'h01 : count_reg; // see R2 see R13
	// low bits from clock phase at 1:1, else from the prescaler
	assign low_bits   = (cfg.pre == PRE_DIV1) ? phase_reg :
	                    (cfg.pre == PRE_DIV4) ? pre_reg[1:0] : pre_reg[3:2]; // see R7
	assign tb.base     = {count_reg, low_bits};                 // see R6
	assign tb.boundary = boundary;
	// postscaler only feeds the match flag
	assign post_next  = !boundary ? post_reg :
	                    (post_reg == cfg.post) ? 4'h0 : post_reg + 4'h1;  // see R4
	assign post_match = boundary & (post_reg == cfg.post);
	assign count      = count_reg;

	// state update
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_reg <= 2'h0;
			pre_reg   <= 4'h0;
			count_reg <= RST_COUNT;
			post_reg  <= 4'h0;
		end else begin
			phase_reg <= phase_next;
			pre_reg   <= pre_next;
			count_reg <= count_next;
			post_reg  <= post_next;
		end
	end

	// counter clears after a period match
	property p_count_clear;
		@(posedge aclk) disable iff (!aresetn) (boundary && !count_wr) |=> count_reg == 8'h00;
	endproperty
	a_count_clear: assert property (p_count_clear) else $error("counter not cleared"); // see R2

	// sleep holds the counter
	property p_sleep_hold;
		@(posedge aclk) disable iff (!aresetn) (sleep && !count_wr) |=> $stable(count_reg);
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("counter moved in sleep"); // see R12

	// at 1:1 the low base bits follow the phase
	property p_low_phase;
		@(posedge aclk) disable iff (!aresetn) (cfg.pre == PRE_DIV1) |-> tb.base[1:0] == phase_reg;
	endproperty
	a_low_phase: assert property (p_low_phase) else $error("low bits not phase"); // see R7

endmodule

/* logic/pwm_channel.sv */
// duty buffering, compare and output level of one pwm channel
`timescale 1ns/10ps
module pwm_channel import pwm_pkg::*; (
	input  logic       aclk,         // system clock
	input  logic       aresetn,      // synchronous reset, low
	input  logic       sleep,        // freeze state
	input  logic       pwm_mode,     // channel in pwm mode
	input  timebase_t  tb,           // shared time base
	input  logic [7:0] duty_low,     // duty low register
	input  logic [1:0] frac,         // duty fraction bits
	input  logic       shadow_wr,    // software write of shadow
	input  logic [7:0] shadow_wdata, // value written
	output logic [7:0] shadow,       // duty shadow register
	output logic       level         // pwm level
);
	logic [7:0] shadow_reg, shadow_next;
	logic [1:0] latch_reg, latch_next;
	logic       level_reg, level_next;
	logic [9:0] duty_new, duty_buf;
	logic       match;

	// duty assembled from low byte and fraction bits
	assign duty_new = {duty_low, frac};                          // see R1
	assign duty_buf = {shadow_reg, latch_reg};
	// duty above the period never meets the base, so no clear
	assign match    = (tb.base == duty_buf);                     // see R8 see R9 see R10
	// in pwm mode both buffer halves reload only at the boundary, outside it software writes the shadow
	assign shadow_next = (pwm_mode & tb.boundary) ? duty_low :
	                     (!pwm_mode & shadow_wr) ? shadow_wdata : shadow_reg; // see R5 see R3
	assign latch_next  = (pwm_mode & tb.boundary) ? frac : latch_reg;         // see R5
	// set at the boundary unless duty is zero, clear on compare
	assign level_next  = !pwm_mode  ? 1'b0 :
	                     sleep      ? level_reg :                              // see R12
	                     tb.boundary ? (duty_new != 10'h000) :                  // see R2
	                     match      ? 1'b0 : level_reg;                        // see R8
	assign shadow = shadow_reg;
	// the compare step itself is already low, so the pulse lasts exactly duty steps
	assign level  = level_reg & ~match;                          // see R8

	// state update
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			shadow_reg <= RST_DUTY;
			latch_reg  <= 2'h0;
			level_reg  <= 1'b0;
		end else begin
			shadow_reg <= shadow_next;
			latch_reg  <= latch_next;
			level_reg  <= level_next;
		end
	end

	sequence s_set;
		pwm_mode && tb.boundary && duty_new != 10'h000;
	endsequence

	sequence s_clear;
		pwm_mode && !sleep && !tb.boundary && match;
	endsequence

	// boundary with nonzero duty raises the pin and loads the duty
	property p_set;
		@(posedge aclk) disable iff (!aresetn) s_set |=> level_reg && shadow_reg == $past(duty_low);
	endproperty
	a_set: assert property (p_set) else $error("boundary did not set level"); // see R2

	// compare match lowers the pin
	property p_clear;
		@(posedge aclk) disable iff (!aresetn) s_clear |=> !level_reg;
	endproperty
	a_clear: assert property (p_clear) else $error("match did not clear level"); // see R8

	// buffer changes only at the boundary while in pwm mode
	property p_buffer;
		@(posedge aclk) disable iff (!aresetn)
			(pwm_mode && !tb.boundary) |=> $stable(duty_buf);
	endproperty
	a_buffer: assert property (p_buffer) else $error("duty buffer changed mid period"); // see R5

	// sleep freezes the level
	property p_sleep_level;
		@(posedge aclk) disable iff (!aresetn) (pwm_mode && sleep) |=> $stable(level_reg);
	endproperty
	a_sleep_level: assert property (p_sleep_level) else $error("level moved in sleep"); // see R12

endmodule

/* logic/pwm_unit.sv */
// axi4-lite register file and pin drive of the two-channel pwm unit
`timescale 1ns/10ps
module pwm_unit import pwm_pkg::*; (
	input  logic        aclk,       // system clock, 40 MHz
	input  logic        aresetn,    // synchronous reset, low
	input  logic        sleep_req,  // sleep request pin, asynchronous
	input  logic [31:0] awaddr,     // write address
	input  logic        awvalid,    // write address valid
	output logic        awready,    // write address ready
	input  logic [31:0] wdata,      // write data
	input  logic [3:0]  wstrb,      // write strobes
	input  logic        wvalid,     // write data valid
	output logic        wready,     // write data ready
	output logic [1:0]  bresp,      // write response
	output logic        bvalid,     // write response valid
	input  logic        bready,     // write response ready
	input  logic [31:0] araddr,     // read address
	input  logic        arvalid,    // read address valid
	output logic        arready,    // read address ready
	output logic [31:0] rdata,      // read data
	output logic [1:0]  rresp,      // read response
	output logic        rvalid,     // read data valid
	input  logic        rready,     // read data ready
	output logic [1:0]  pin_out,    // pwm pin levels
	output logic [1:0]  pin_oe      // pwm pin output enables
);
	typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} wr_state_t;
	typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_RESP = 2'b10} rd_state_t;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic hit(input logic [31:0] addr, input logic [7:0] off);
		hit = (addr == {24'h000000, off});
	endfunction

	function automatic logic known(input logic [31:0] addr);
		known = hit(addr, OFF_CTL1) | hit(addr, OFF_CTL2) | hit(addr, OFF_DUTY1) |
		        hit(addr, OFF_DUTY2) | hit(addr, OFF_SHAD1) | hit(addr, OFF_SHAD2) |
		        hit(addr, OFF_PERIOD) | hit(addr, OFF_TCTL) | hit(addr, OFF_COUNT) |
		        hit(addr, OFF_STATUS) | hit(addr, OFF_DIR);
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	wr_state_t   wr_state_reg, wr_state_next;
	rd_state_t   rd_state_reg, rd_state_next;
	logic        awready_reg, awready_next;
	logic        bvalid_reg, bvalid_next;
	logic [1:0]  bresp_reg, bresp_next;
	logic        arready_reg, arready_next;
	logic        rvalid_reg, rvalid_next;
	logic [1:0]  rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [5:0]  ctl1_reg, ctl1_next;
	logic [5:0]  ctl2_reg, ctl2_next;
	logic [7:0]  duty1_reg, duty1_next;
	logic [7:0]  duty2_reg, duty2_next;
	logic [7:0]  period_reg, period_next;
	logic [6:0]  tctl_reg, tctl_next;
	logic [1:0]  dir_reg, dir_next;
	logic        flag_reg, flag_next;
	logic [1:0]  pin_out_reg, pin_oe_reg;
	logic        sleep_meta_reg, sleep_reg;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	logic        wr_fire, rd_fire, wr_en;
	logic [7:0]  wbyte;
	logic        pwm1, pwm2, post_match;
	logic [7:0]  count, shadow1, shadow2;
	logic [1:0]  level;
	timer_cfg_t  cfg;
	timebase_t   tb;
	logic [31:0] rd_value;

	// a write lands when both channels are taken together
	assign wr_fire = awready_reg & awvalid & wvalid;
	assign rd_fire = arready_reg & arvalid;
	assign wr_en   = wr_fire & wstrb[0];
	assign wbyte   = wdata[7:0];

	// pwm mode per unit from the upper mode bits
	assign pwm1 = (ctl1_reg[CTL_MODE_LSB+3 -: 2] == MODE_PWM);
	assign pwm2 = (ctl2_reg[CTL_MODE_LSB+3 -: 2] == MODE_PWM);

	// timer control fields
	assign cfg.run  = tctl_reg[TCTL_RUN_BIT];                         // see R19
	assign cfg.pre  = tctl_reg[TCTL_PRE_LSB +: 2];                    // see R19
	assign cfg.post = tctl_reg[TCTL_POST_LSB +: 4];                   // see R19

	// register next values, low byte lane only
	assign ctl1_next   = (wr_en & hit(awaddr, OFF_CTL1)) ? wbyte[5:0] : ctl1_reg;   // see R18
	assign ctl2_next   = (wr_en & hit(awaddr, OFF_CTL2)) ? wbyte[5:0] : ctl2_reg;   // see R18
	assign duty1_next  = (wr_en & hit(awaddr, OFF_DUTY1)) ? wbyte : duty1_reg;      // see R1
	assign duty2_next  = (wr_en & hit(awaddr, OFF_DUTY2)) ? wbyte : duty2_reg;      // see R1
	assign period_next = (wr_en & hit(awaddr, OFF_PERIOD)) ? wbyte : period_reg;
	assign tctl_next   = (wr_en & hit(awaddr, OFF_TCTL)) ? wbyte[6:0] : tctl_reg;
	assign dir_next    = (wr_en & hit(awaddr, OFF_DIR)) ? wbyte[1:0] : dir_reg;
	// match flag: hardware set wins over write-one-to-clear
	assign flag_next   = post_match |
	                     (flag_reg & ~(wr_en & hit(awaddr, OFF_STATUS) & wbyte[STAT_FLAG_BIT]));

	// read selection, unimplemented bits read zero
	assign rd_value =
		hit(araddr, OFF_CTL1)   ? {26'h0, ctl1_reg} :                      // see R18
		hit(araddr, OFF_CTL2)   ? {26'h0, ctl2_reg} :
		hit(araddr, OFF_DUTY1)  ? {24'h000000, duty1_reg} :
		hit(araddr, OFF_DUTY2)  ? {24'h000000, duty2_reg} :
		hit(araddr, OFF_SHAD1)  ? {24'h000000, shadow1} :
		hit(araddr, OFF_SHAD2)  ? {24'h000000, shadow2} :
		hit(araddr, OFF_PERIOD) ? {24'h000000, period_reg} :
		hit(araddr, OFF_TCTL)   ? {25'h0, tctl_reg} :
		hit(araddr, OFF_COUNT)  ? {24'h000000, count} :
		hit(araddr, OFF_STATUS) ? {31'h0, flag_reg} :
		hit(araddr, OFF_DIR)    ? {30'h0, dir_reg} : 32'h00000000;

	// ----------------------------------------
	// bus handshake
	// ----------------------------------------
	// write side: ready pulses once both address and data are offered
	always_comb begin
		wr_state_next = wr_state_reg;
		awready_next  = 1'b0;
		bvalid_next   = bvalid_reg;
		bresp_next    = bresp_reg;
		unique case (wr_state_reg)
			WR_IDLE: begin
				if (wr_fire) begin
					wr_state_next = WR_RESP;
					bvalid_next   = 1'b1;
					bresp_next    = known(awaddr) ? RESP_OKAY : RESP_SLVERR;
				end else begin
					awready_next = awvalid & wvalid & ~awready_reg;
				end
			end
			WR_RESP: begin
				if (bready) begin
					wr_state_next = WR_IDLE;
					bvalid_next   = 1'b0;
				end
			end
			default: begin
				wr_state_next = WR_IDLE;
				bvalid_next   = 1'b0;
			end
		endcase
	end

	// read side: data is captured at the address handshake
	always_comb begin
		rd_state_next = rd_state_reg;
		arready_next  = 1'b0;
		rvalid_next   = rvalid_reg;
		rresp_next    = rresp_reg;
		rdata_next    = rdata_reg;
		unique case (rd_state_reg)
			RD_IDLE: begin
				if (rd_fire) begin
					rd_state_next = RD_RESP;
					rvalid_next   = 1'b1;
					rdata_next    = rd_value;
					rresp_next    = known(araddr) ? RESP_OKAY : RESP_SLVERR;
				end else begin
					arready_next = arvalid & ~arready_reg;
				end
			end
			RD_RESP: begin
				if (rready) begin
					rd_state_next = RD_IDLE;
					rvalid_next   = 1'b0;
				end
			end
			default: begin
				rd_state_next = RD_IDLE;
				rvalid_next   = 1'b0;
			end
		endcase
	end

	// bus flops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_reg <= WR_IDLE;
			rd_state_reg <= RD_IDLE;
			awready_reg  <= 1'b0;
			bvalid_reg   <= 1'b0;
			bresp_reg    <= RESP_OKAY;
			arready_reg  <= 1'b0;
			rvalid_reg   <= 1'b0;
			rresp_reg    <= RESP_OKAY;
			rdata_reg    <= 32'h00000000;
		end else begin
			wr_state_reg <= wr_state_next;
			rd_state_reg <= rd_state_next;
			awready_reg  <= awready_next;
			bvalid_reg   <= bvalid_next;
			bresp_reg    <= bresp_next;
			arready_reg  <= arready_next;
			rvalid_reg   <= rvalid_next;
			rresp_reg    <= rresp_next;
			rdata_reg    <= rdata_next;
		end
	end

	// ----------------------------------------
	// registers and pins
	// ----------------------------------------
	// any reset restores defaults and releases both pins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl1_reg    <= RST_CTL;                    // see R15
			ctl2_reg    <= RST_CTL;
			duty1_reg   <= RST_DUTY;
			duty2_reg   <= RST_DUTY;
			period_reg  <= RST_PERIOD;
			tctl_reg    <= RST_TCTL;
			dir_reg     <= RST_DIR;                    // see R15
			flag_reg    <= 1'b0;
			pin_out_reg <= 2'h0;
			pin_oe_reg  <= 2'h0;
		end else begin
			ctl1_reg    <= ctl1_next;
			ctl2_reg    <= ctl2_next;
			duty1_reg   <= duty1_next;
			duty2_reg   <= duty2_next;
			period_reg  <= period_next;
			tctl_reg    <= tctl_next;
			dir_reg     <= dir_next;
			flag_reg    <= flag_next;
			pin_out_reg <= level;                      // see R20
			pin_oe_reg  <= {pwm2, pwm1} & ~dir_reg;    // see R20
		end
	end

	// sleep pin passes two flops before use
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sleep_meta_reg <= 1'b0;
			sleep_reg      <= 1'b0;
		end else begin
			sleep_meta_reg <= sleep_req;
			sleep_reg      <= sleep_meta_reg;
		end
	end

	// ----------------------------------------
	// datapath
	// ----------------------------------------
	pwm_timebase u_timebase (
		.aclk        (aclk),
		.aresetn     (aresetn),
		.sleep       (sleep_reg),
		.cfg         (cfg),
		.period      (period_reg),
		.count_wr    (wr_en & hit(awaddr, OFF_COUNT)),
		.count_wdata (wbyte),
		.tb          (tb),
		.count       (count),
		.post_match  (post_match)
	);

	pwm_channel u_chan1 (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.sleep        (sleep_reg),
		.pwm_mode     (pwm1),
		.tb           (tb),
		.duty_low     (duty1_reg),
		.frac         (ctl1_reg[CTL_FRAC_LSB +: 2]),
		.shadow_wr    (wr_en & hit(awaddr, OFF_SHAD1)),   // see R3
		.shadow_wdata (wbyte),
		.shadow       (shadow1),
		.level        (level[0])
	);

	pwm_channel u_chan2 (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.sleep        (sleep_reg),
		.pwm_mode     (pwm2),
		.tb           (tb),
		.duty_low     (duty2_reg),
		.frac         (ctl2_reg[CTL_FRAC_LSB +: 2]),
		.shadow_wr    (wr_en & hit(awaddr, OFF_SHAD2)),
		.shadow_wdata (wbyte),
		.shadow       (shadow2),
		.level        (level[1])
	);

	// outputs
	assign awready = awready_reg;
	assign wready  = awready_reg;
	assign bvalid  = bvalid_reg;
	assign bresp   = bresp_reg;
	assign arready = arready_reg;
	assign rvalid  = rvalid_reg;
	assign rresp   = rresp_reg;
	assign rdata   = rdata_reg;
	assign pin_out = pin_out_reg;
	assign pin_oe  = pin_oe_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// after reset both pins are released
	property p_reset_pins;
		@(posedge aclk) !aresetn |=> pin_oe == 2'h0 && dir_reg == RST_DIR;
	endproperty
	a_reset_pins: assert property (p_reset_pins) else $error("pins not released by reset"); // see R15

	// shadow write in pwm mode has no effect
	property p_shadow_ro;
		@(posedge aclk) disable iff (!aresetn)
			(wr_en && hit(awaddr, OFF_SHAD1) && pwm1 && !tb.boundary) |=> $stable(shadow1);
	endproperty
	a_shadow_ro: assert property (p_shadow_ro) else $error("shadow written in pwm mode"); // see R3

	// pin 0 is enabled only in pwm mode with direction set to output
	property p_pin_dir;
		@(posedge aclk) disable iff (!aresetn)
			pin_oe[0] |-> $past(pwm1) && !$past(dir_reg[0]);
	endproperty
	a_pin_dir: assert property (p_pin_dir) else $error("pin driven while input"); // see R20

	// unimplemented control bits read as zero
	property p_ctl_read;
		@(posedge aclk) disable iff (!aresetn)
			(rd_fire && hit(araddr, OFF_CTL1)) |=> rvalid && rdata[31:6] == 26'h0;
	endproperty
	a_ctl_read: assert property (p_ctl_read) else $error("control upper bits nonzero"); // see R18

endmodule

/* test/pwm_load.sv */
// external load model watching one pwm pin
`timescale 1ns/10ps
module pwm_load (
	input  logic        aclk,     // system clock
	input  logic        clr,      // restart the counts
	input  logic        pin_out,  // pin level driven
	input  logic        pin_oe,   // pin driven when high
	output logic [15:0] high_cnt, // cycles seen high
	output logic [15:0] rise_cnt  // rising edges seen
);
	logic pin, last;
	// an undriven pin falls to the pull-down level
	assign pin = pin_oe & pin_out;
	// count level and edges seen at the pin
	always_ff @(posedge aclk) begin
		last <= pin;
		if (clr) begin
			high_cnt <= '0;
			rise_cnt <= '0;
		end else begin
			high_cnt <= high_cnt + 16'(pin);
			rise_cnt <= rise_cnt + 16'(pin & ~last);
		end
	end
endmodule

/* test/tb_top.sv */
// self-checking bench of the two-channel pwm unit
`timescale 1ns/10ps
module tb_top import pwm_pkg::*;;
	logic aclk, aresetn, sleep_req, awvalid, wvalid, bready, arvalid, rready, clr;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] awaddr, wdata, araddr, rdata, q, c1, c2;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, pin_out, pin_oe;
	logic [15:0] hi, ri;
	int          n_mismatch, check_count, i;
	pwm_unit dut (.aclk(aclk), .aresetn(aresetn), .sleep_req(sleep_req), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .pin_out(pin_out), .pin_oe(pin_oe));
	pwm_load load (.aclk(aclk), .clr(clr), .pin_out(pin_out[0]), .pin_oe(pin_oe[0]),
		.high_cnt(hi), .rise_cnt(ri));
	// ----------------------------------------
	// checking and bus tasks
	// ----------------------------------------
	task automatic final_report();
		if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", n, e, g);
			n_mismatch++;
		end
	endtask
	// one axi4-lite write or read, held until the answer is sampled
	task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic [1:0] r);
		bit ad, wd;
		int k;
		ad = 0;
		wd = 0;
		if (w) begin
			awaddr <= {24'h0, a};
			wdata <= d;
			wstrb <= 4'hf;
			awvalid <= 1;
			wvalid <= 1;
			bready <= 1;
		end else begin
			araddr <= {24'h0, a};
			arvalid <= 1;
			rready <= 1;
		end
		for (k = 0; k < 60; k++) begin
			@(posedge aclk);
			if (w && ad && wd && bvalid === 1'b1) begin
				r = bresp;
				break;
			end
			if (!w && ad && rvalid === 1'b1) begin
				r = rresp;
				rd = rdata;
				break;
			end
			if (awready === 1'b1) begin
				awvalid <= 0;
				ad = 1;
			end
			if (wready === 1'b1) begin
				wvalid <= 0;
				wd = 1;
			end
			if (arready === 1'b1) begin
				arvalid <= 0;
				ad = 1;
			end
		end
		bready <= 0;
		rready <= 0;
		// let an edge pass so the next call never reassigns a ready in this step
		@(posedge aclk);
		if (k == 60) begin
			chk("bus_wait", 0, 1);
			final_report();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		xfer(1, a, d, q, r);
		chk("wresp", RESP_OKAY, r);
	endtask
	task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
		logic [1:0] r;
		xfer(0, a, 0, q, r);
		chk(n, e, q);
	endtask
	// pin statistics over 320 cycles
	task automatic meas(input string n, input logic [15:0] eh, input logic [15:0] er);
		repeat (128) @(posedge aclk);
		clr <= 1;
		@(posedge aclk);
		clr <= 0;
		repeat (320) @(posedge aclk);
		#1;
		chk(n, {eh, er}, {hi, ri});
	endtask
	// ----------------------------------------
	// clock and scenarios
	// ----------------------------------------
	initial begin
		aclk = 0;
		forever #12.5 aclk = ~aclk;
	end
	initial begin
		logic [1:0] r;
		{aresetn, sleep_req, awvalid, wvalid, bready, arvalid, rready, clr} = '0;
		{awaddr, wdata, araddr, wstrb} = '0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rd("period_rst", OFF_PERIOD, 32'hff);
		rd("dir_rst", OFF_DIR, 32'h3);
		chk("oe_rst", 2'h0, pin_oe);
		wr(OFF_DIR, 3);
		wr(OFF_PERIOD, 0);
		wr(OFF_CTL1, 32'hdc);
		rd("ctl_bits", OFF_CTL1, 32'h1c);
		wr(OFF_DUTY1, 0);
		wr(OFF_STATUS, 1);
		wr(OFF_TCTL, 4);
		for (i = 0; i < 50 && q[0] !== 1'b1; i++) xfer(0, OFF_STATUS, 0, q, r);
		chk("flag", 1, q[0]);
		wr(OFF_DIR, 2);
		chk("oe_on", 2'h1, pin_oe);
		for (i = 0; i < 3; i++) begin
			wr(OFF_TCTL, 4 + i);
			meas("ratio", 80, 16'(80 >> (2 * i)));
		end
		wr(OFF_TCTL, 4);
		wr(OFF_CTL1, 32'h0c);
		meas("zero", 0, 0);
		wr(OFF_DUTY1, 32'h5a);
		meas("over", 320, 0);
		rd("shadow", OFF_SHAD1, 32'h5a);
		wr(OFF_SHAD1, 32'h11);
		rd("shadow_ro", OFF_SHAD1, 32'h5a);
		xfer(1, 8'h30, 0, q, r);
		chk("unmapped_w", RESP_SLVERR, r);
		xfer(0, 8'h30, 0, q, r);
		chk("unmapped_r", RESP_SLVERR, r);
		wr(OFF_PERIOD, 32'hff);
		sleep_req <= 1;
		repeat (5) @(posedge aclk);
		xfer(0, OFF_COUNT, 0, c1, r);
		repeat (40) @(posedge aclk);
		xfer(0, OFF_COUNT, 0, c2, r);
		chk("sleep", c1, c2);
		sleep_req <= 0;
		repeat (8) @(posedge aclk);
		xfer(0, OFF_COUNT, 0, q, r);
		chk("wake", 1, q - c2 > 0 && q - c2 < 9);
		wr(OFF_TCTL, 32'hff);
		rd("tctl_bits", OFF_TCTL, 32'h7f);
		chk("pin2_idle", 0, pin_out[1]);
		final_report();
	end
endmodule
